// ---- hdl/led_sink_consts.svh ----
`ifndef LED_SINK_CONSTS_SVH
`define LED_SINK_CONSTS_SVH
// Wishbone byte addresses
`define ADR_CTRL 8'h00
`define ADR_STATUS 8'h04
`define ADR_REPORT 8'h08
`define ADR_IMAGE 8'h0c
// Control reset: detection decoding enabled
`define CTRL_RST 1'h1
// Shift-clock counts that pick a sequence
`define CNT_OPEN 3'h1
`define CNT_GND 3'h2
`define CNT_SHORT 3'h3
`define CNT_CMD 3'h4
`define CNT_MAX 3'h7
// Thermal flag slots in the command shift register
`define WARM_POS 9
`define HOT_POS 8
`define SHUT_POS 7
// Channel stagger: unit delay in ns, clock in MHz
`define UNIT_NS 3
`define CLK_MHZ 100
`define UNIT_CYC ((`UNIT_NS * `CLK_MHZ + 999) / 1000)
`define PIPE_LEN (3 * `UNIT_CYC)
`endif

// ---- hdl/led_sink_pkg.sv ----
package led_sink_pkg;
  // Gray along idle, count, smart1, smart2, run
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_COUNT = 3'h1,
    ST_SMART1 = 3'h3,
    ST_SMART2 = 3'h2,
    ST_RUN = 3'h6
  } seq_state_t;
  // Equal to the shift-clock count that selects it
  typedef enum logic [1:0] {
    DET_NONE = 2'h0,
    DET_OPEN = 2'h1,
    DET_GND = 2'h2,
    DET_SHORT = 2'h3
  } det_type_t;
endpackage

// ---- hdl/led_sink_fault_detect.sv ----
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "led_sink_consts.svh"
// Notes on behaviour
// - One clock edge, strobe high: realtime open
// - Three edges, strobe high: realtime short
// - Two edges, strobe high: realtime ground short
// - One edge, two strobe falls: smart open
// - Three edges, two strobe falls: smart short
// - Two edges, two strobe falls: smart ground
// - Fault results loaded into shift register
// - Realtime open/short tests lit channels only
// - Unlit or blanked channels report zero
// - Ground test on unlit channels, low flags
// - Lit channels or unblanked report zero
// - Plain latching shifts image data out
// - Open: driven channel reading below threshold
// - Short: lit channel reading above supply
// - Smart open/short: test current till clock
// - Smart short: off channel above supply
// - Blank input ignored by smart detection
// - Smart ground: outputs off till clock
// - Four groups, unit stagger within group
// - Warm flag shifted out in command mode
// - Hot shuts outputs, resumes below warm
// - Thermal flags only in command mode
// - Four edges then strobe fall: command mode
// - Strobe rise latches image, one lights
module led_sink_fault_detect (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_shift_clk,
  input wire logic i_serial_in,
  input wire logic i_strobe_n,
  input wire logic i_blank,
  input wire logic [15:0] i_chan_low,
  input wire logic [15:0] i_chan_high,
  input wire logic i_temp_warm,
  input wire logic i_temp_hot,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  output logic o_serial_out,
  output logic [15:0] o_sink_channels,
  output logic o_test_current,
  output logic o_shutdown
);
  led_sink_pkg::seq_state_t st_q;
  led_sink_pkg::det_type_t type_q;
  logic clk_q, stb_q;
  logic [2:0] cnt_q;
  logic [15:0] sh_q, img_q, report_q;
  logic [15:0] low_m_q, low_s_q, high_m_q, high_s_q;
  logic [1:0] tmp_m_q, tmp_s_q;
  logic cmd_q, shut_q, ctrl_q, ack_q;
  logic [31:0] dat_q;
  logic [15:0] pipe_q [0:`PIPE_LEN-1];
  logic [15:0] target, sink_d, rt_rep, sm_rep, sh_shift;
  logic [31:0] rd_d;
  logic clk_rise, stb_rise, stb_fall;
  logic rt_load, sm_load, cmd_enter, cnt_det, run;
  logic wb_req;

  // Pins arrive synchronous; one stage for edges
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      clk_q <= 1'b0;
      stb_q <= 1'b1;
    end else begin
      clk_q <= i_shift_clk;
      stb_q <= i_strobe_n;
    end
  end
  assign clk_rise = i_shift_clk & ~clk_q;
  assign stb_rise = i_strobe_n & ~stb_q;
  assign stb_fall = ~i_strobe_n & stb_q;

  // Comparators and sensor are analog, two flops each
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      low_m_q <= 16'h0000;
      low_s_q <= 16'h0000;
      high_m_q <= 16'h0000;
      high_s_q <= 16'h0000;
      tmp_m_q <= 2'h0;
      tmp_s_q <= 2'h0;
    end else begin
      low_m_q <= i_chan_low;
      low_s_q <= low_m_q;
      high_m_q <= i_chan_high;
      high_s_q <= high_m_q;
      tmp_m_q <= {i_temp_hot, i_temp_warm};
      tmp_s_q <= tmp_m_q;
    end
  end

  // Sequence decode events
  assign cnt_det = (cnt_q >= `CNT_OPEN) && (cnt_q <= `CNT_SHORT) && ctrl_q;
  assign rt_load = (st_q == led_sink_pkg::ST_COUNT) && stb_fall && cnt_det && !i_shift_clk;
  assign cmd_enter = (st_q == led_sink_pkg::ST_COUNT) && stb_fall && (cnt_q == `CNT_CMD);
  assign run = (st_q == led_sink_pkg::ST_RUN);
  assign sm_load = run && clk_rise;

  // Edge counter and detection state
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      st_q <= led_sink_pkg::ST_IDLE;
      cnt_q <= 3'h0;
      type_q <= led_sink_pkg::DET_NONE;
    end else begin
      unique case (st_q)
        led_sink_pkg::ST_IDLE: begin
          cnt_q <= 3'h0;
          if (stb_rise) begin
            st_q <= led_sink_pkg::ST_COUNT;
          end
        end
        led_sink_pkg::ST_COUNT: begin
          // Count saturates so long bursts never alias
          if (clk_rise && cnt_q != `CNT_MAX) begin
            cnt_q <= cnt_q + 3'h1;
          end
          if (stb_fall) begin
            type_q <= led_sink_pkg::det_type_t'(cnt_q[1:0]);
            if (cnt_det && i_shift_clk) begin
              st_q <= led_sink_pkg::ST_SMART1;
            end else begin
              st_q <= led_sink_pkg::ST_IDLE;
            end
          end
        end
        led_sink_pkg::ST_SMART1: begin
          // Any clock edge here aborts the smart request
          if (clk_rise) begin
            st_q <= led_sink_pkg::ST_IDLE;
          end else if (stb_rise) begin
            st_q <= led_sink_pkg::ST_SMART2;
          end
        end
        led_sink_pkg::ST_SMART2: begin
          if (clk_rise) begin
            st_q <= led_sink_pkg::ST_IDLE;
          end else if (stb_fall) begin
            st_q <= i_shift_clk ? led_sink_pkg::ST_RUN : led_sink_pkg::ST_IDLE;
          end
        end
        led_sink_pkg::ST_RUN: begin
          if (clk_rise) begin
            st_q <= led_sink_pkg::ST_IDLE;
          end
        end
        default: begin
          st_q <= led_sink_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Realtime report; blank gates per test kind
  always_comb begin
    unique case (cnt_q[1:0])
      2'h1: rt_rep = img_q & {16{~i_blank}} & low_s_q;
      2'h2: rt_rep = ~img_q & {16{i_blank}} & low_s_q;
      2'h3: rt_rep = img_q & {16{~i_blank}} & high_s_q;
      default: rt_rep = 16'h0000;
    endcase
  end

  // Smart report never looks at blank
  always_comb begin
    unique case (type_q)
      led_sink_pkg::DET_SHORT: sm_rep = ~img_q & high_s_q;
      led_sink_pkg::DET_NONE: sm_rep = 16'h0000;
      default: sm_rep = low_s_q;
    endcase
  end
  assign sh_shift = {sh_q[14:0], i_serial_in};

  // Shift register; a load replaces that clock's shift
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      sh_q <= 16'h0000;
    end else if (rt_load) begin
      sh_q <= rt_rep;
    end else if (sm_load) begin
      sh_q <= sm_rep;
    end else if (cmd_enter) begin
      sh_q <= 16'h0000;
      sh_q[`WARM_POS] <= tmp_s_q[0];
      sh_q[`HOT_POS] <= tmp_s_q[1];
      sh_q[`SHUT_POS] <= shut_q;
    end else if (clk_rise) begin
      sh_q <= sh_shift;
    end
  end

  // Last report kept for software
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      report_q <= 16'h0000;
    end else if (rt_load) begin
      report_q <= rt_rep;
    end else if (sm_load) begin
      report_q <= sm_rep;
    end
  end

  // Mode and image latch; command bits themselves unused
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cmd_q <= 1'b0;
      img_q <= 16'h0000;
    end else if (cmd_enter) begin
      cmd_q <= 1'b1;
    end else if (stb_rise && st_q == led_sink_pkg::ST_IDLE) begin
      if (cmd_q) begin
        cmd_q <= 1'b0;
      end else begin
        img_q <= sh_q;
      end
    end
  end

  // Shutdown holds until the warm level clears
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      shut_q <= 1'b0;
    end else if (tmp_s_q[1]) begin
      shut_q <= 1'b1;
    end else if (!tmp_s_q[0]) begin
      shut_q <= 1'b0;
    end
  end

  // Drive request before stagger
  always_comb begin
    if (shut_q || (run && type_q == led_sink_pkg::DET_GND)) begin
      target = 16'h0000;
    end else if (run) begin
      target = 16'hffff;
    end else begin
      target = img_q & {16{~i_blank}};
    end
  end

  // Stagger pipe; turn-off is immediate
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      for (int k = 0; k < `PIPE_LEN; k++) begin
        pipe_q[k] <= 16'h0000;
      end
    end else begin
      pipe_q[0] <= target;
      for (int k = 1; k < `PIPE_LEN; k++) begin
        pipe_q[k] <= pipe_q[k-1];
      end
    end
  end
  for (genvar n = 0; n < 16; n++) begin : g_stag
    localparam int P = (n % 4) * `UNIT_CYC;
    if (P == 0) begin : g_now
      assign sink_d[n] = target[n];
    end else begin : g_dly
      assign sink_d[n] = target[n] & pipe_q[P-1][n];
    end
  end

  // Registered pin outputs
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_sink_channels <= 16'h0000;
      o_test_current <= 1'b0;
      o_serial_out <= 1'b0;
      o_shutdown <= 1'b0;
    end else begin
      o_sink_channels <= sink_d;
      o_test_current <= run && type_q != led_sink_pkg::DET_GND && !shut_q;
      o_serial_out <= cmd_q ? sh_q[`WARM_POS] : sh_q[15];
      o_shutdown <= shut_q;
    end
  end

  // Wishbone slave, one wait state, unmapped reads zero
  assign wb_req = i_wb_cyc && i_wb_stb && !ack_q;
  always_comb begin
    unique case (i_wb_adr)
      `ADR_CTRL: rd_d = {31'h0, ctrl_q};
      `ADR_STATUS: rd_d = {25'h0, shut_q, tmp_s_q, cmd_q, st_q};
      `ADR_REPORT: rd_d = {16'h0, report_q};
      `ADR_IMAGE: rd_d = {16'h0, img_q};
      default: rd_d = 32'h0;
    endcase
  end
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
      ctrl_q <= `CTRL_RST;
    end else begin
      ack_q <= wb_req;
      dat_q <= wb_req ? rd_d : 32'h0;
      if (wb_req && i_wb_we && i_wb_sel[0] && i_wb_adr == `ADR_CTRL) begin
        ctrl_q <= i_wb_dat[0];
      end
    end
  end
  assign o_wb_ack = ack_q;
  assign o_wb_dat = dat_q;

  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  logic [15:0] rt_open_v, rt_gnd_v, rt_short_v;
  assign rt_open_v = img_q & {16{~i_blank}} & low_s_q;
  assign rt_gnd_v = ~img_q & {16{i_blank}} & low_s_q;
  assign rt_short_v = img_q & {16{~i_blank}} & high_s_q;

  rt_open_load_a: assert property (rt_load && cnt_q == `CNT_OPEN |=> sh_q == $past(rt_open_v))
    else $error("open report wrong");
  rt_gnd_load_a: assert property (rt_load && cnt_q == `CNT_GND |=> sh_q == $past(rt_gnd_v))
    else $error("ground report wrong");
  rt_short_load_a: assert property (rt_load && cnt_q == `CNT_SHORT |=> sh_q == $past(rt_short_v))
    else $error("short report wrong");
  cmd_entry_a: assert property (cmd_enter |=> cmd_q ##1 o_serial_out == $past(tmp_s_q[0], 2))
    else $error("command entry or warm flag wrong");
  smart_current_a: assert property (run && type_q != led_sink_pkg::DET_GND && !shut_q |=> o_test_current)
    else $error("test current missing");
  smart_gnd_off_a: assert property (run && type_q == led_sink_pkg::DET_GND |=> o_sink_channels == 16'h0000)
    else $error("outputs not forced off");
  shutdown_off_a: assert property (shut_q |=> o_sink_channels == 16'h0000 && o_shutdown)
    else $error("shutdown not honoured");
  image_shift_a: assert property (clk_rise && !rt_load && !sm_load && !cmd_enter |=> sh_q == $past(sh_shift))
    else $error("image shift wrong");
  smart_arm_a: assert property (st_q == led_sink_pkg::ST_SMART2 && stb_fall && i_shift_clk && !clk_rise
    |=> run)
    else $error("smart run not entered");
  stagger_a: assert property ($rose(o_sink_channels[1]) |-> $past(target[1], `UNIT_CYC + 1))
    else $error("stagger wrong");


  // Report contents, image latch and mode entry; skipped channels must read zero
  rt_blank_skip_a: assert property (rt_load && cnt_q == `CNT_OPEN && i_blank |=> sh_q == 16'h0000)
    else $error("blanked open report not zero");
  rt_gnd_lit_a: assert property (rt_load && cnt_q == `CNT_GND && !i_blank |=> sh_q == 16'h0000)
    else $error("unblanked ground report not zero");
  smart_open_a: assert property (sm_load && type_q == led_sink_pkg::DET_OPEN |=> sh_q == $past(low_s_q))
    else $error("smart open report wrong");
  smart_short_a: assert property (sm_load && type_q == led_sink_pkg::DET_SHORT
    |=> sh_q == $past(~img_q & high_s_q))
    else $error("smart short report wrong");
  smart_exit_a: assert property (run && clk_rise |=> st_q == led_sink_pkg::ST_IDLE ##1 !o_test_current)
    else $error("smart run did not end");
  gnd_no_current_a: assert property (run && type_q == led_sink_pkg::DET_GND |=> !o_test_current)
    else $error("test current during ground test");
  image_latch_a: assert property (stb_rise && st_q == led_sink_pkg::ST_IDLE && !cmd_q
    |=> img_q == $past(sh_q))
    else $error("image not latched");
  cmd_thermal_a: assert property (cmd_enter
    |=> sh_q[15:10] == 6'h00 && sh_q[`HOT_POS] == $past(tmp_s_q[1]) && sh_q[`SHUT_POS] == $past(shut_q))
    else $error("command frame thermal bits wrong");
  image_out_a: assert property (!cmd_q |=> o_serial_out == $past(sh_q[15]))
    else $error("serial out not image data");
  hot_shut_a: assert property (tmp_s_q[1] |=> shut_q)
    else $error("hot flag did not shut down");

  // Main scenarios reached by the bench
  cover_rt_c: cover property (rt_load);
  cover_smart_c: cover property (sm_load);
  cover_cmd_c: cover property (cmd_enter);
  cover_smart_gnd_c: cover property (sm_load && type_q == led_sink_pkg::DET_GND);
  cover_shut_c: cover property ($rose(shut_q));
endmodule

// ---- dv/display_ctrl_model.sv ----
`timescale 1ns/100ps
// Display controller that drives the serial pins of the sink
module display_ctrl_model (
  input wire logic i_clock,
  input wire logic i_serial_out,
  output logic o_shift_clk,
  output logic o_serial_in,
  output logic o_strobe_n
);
  // Idle pins: clock low, strobe high
  initial begin
    o_shift_clk = 1'h0;
    o_serial_in = 1'h0;
    o_strobe_n = 1'h1;
  end

  // Five cycles per level, so the pin sampler and serial out settle
  task automatic pins(input logic c, input logic d, input logic s);
    @(posedge i_clock);
    o_shift_clk <= c;
    o_serial_in <= d;
    o_strobe_n <= s;
    repeat (4) @(posedge i_clock);
  endtask

  // Image frame, first bit in ends up on channel 15
  task automatic load_image(input logic [15:0] img);
    for (int i = 15; i >= 0; i--) begin
      pins(1'h0, img[i], 1'h0);
      pins(1'h1, img[i], 1'h0);
    end
    pins(1'h0, 1'h0, 1'h0);
    pins(1'h0, 1'h0, 1'h1);
  endtask

  // Clock rises under a high strobe, then one or two strobe falls
  task automatic select(input int n, input logic smart);
    for (int i = 0; i < n; i++) begin
      pins(1'h0, 1'h0, 1'h1);
      pins(1'h1, 1'h0, 1'h1);
    end
    pins(smart, 1'h0, 1'h1);
    pins(smart, 1'h0, 1'h0);
    if (smart) begin
      pins(1'h1, 1'h0, 1'h1);
      pins(1'h1, 1'h0, 1'h0);
    end
  endtask

  // Image goes back in while the report comes out, so the latch keeps it
  task automatic read_report(input logic [15:0] img, output logic [15:0] rep);
    for (int i = 15; i >= 0; i--) begin
      pins(1'h0, img[i], 1'h0);
      rep[i] = i_serial_out;
      pins(1'h1, img[i], 1'h0);
    end
    pins(1'h0, 1'h0, 1'h1);
  endtask
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/100ps
`include "led_sink_consts.svh"
module testbench;
  localparam logic [15:0] img = 16'h0ff0;
  logic i_clock, i_reset, i_blank, i_temp_warm, i_temp_hot, shift_clk, serial_in, strobe_n;
  logic i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, o_serial_out, o_test_current, o_shutdown;
  logic [15:0] i_chan_low, i_chan_high, o_sink_channels, rep;
  logic [7:0] i_wb_adr;
  logic [31:0] i_wb_dat, o_wb_dat, rd;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  int t_on [16];

  led_sink_fault_detect i_led_sink_fault_detect (.i_clock(i_clock), .i_reset(i_reset),
    .i_shift_clk(shift_clk), .i_serial_in(serial_in), .i_strobe_n(strobe_n), .i_blank(i_blank),
    .i_chan_low(i_chan_low), .i_chan_high(i_chan_high), .i_temp_warm(i_temp_warm),
    .i_temp_hot(i_temp_hot), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr), .i_wb_sel(4'hf), .i_wb_dat(i_wb_dat), .o_wb_ack(o_wb_ack),
    .o_wb_dat(o_wb_dat), .o_serial_out(o_serial_out), .o_sink_channels(o_sink_channels),
    .o_test_current(o_test_current), .o_shutdown(o_shutdown));
  display_ctrl_model i_display_ctrl_model (.i_clock(i_clock), .i_serial_out(o_serial_out),
    .o_shift_clk(shift_clk), .o_serial_in(serial_in), .o_strobe_n(strobe_n));

  // Free-running system clock
  initial begin
    i_clock = 1'h0;
    forever #5 i_clock = ~i_clock;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Classic single cycle; held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    output logic [31:0] q);
    @(posedge i_clock);
    i_wb_cyc <= 1'h1;
    i_wb_stb <= 1'h1;
    i_wb_we <= we;
    i_wb_adr <= adr;
    i_wb_dat <= dat;
    // If ack never comes, only the hang guard ends this wait
    do @(posedge i_clock); while (o_wb_ack !== 1'h1);
    q = o_wb_dat;
    i_wb_cyc <= 1'h0;
    i_wb_stb <= 1'h0;
  endtask

  // Report expected for a detection kind, smart flag and blank level
  function automatic logic [15:0] expect_rep(input int n, input int s, input int b);
    logic [15:0] on;
    on = b ? 16'h0 : img;
    if (s) return n == 3 ? ~img & i_chan_high : i_chan_low;
    case (n)
      1: return on & i_chan_low;
      2: return b ? ~img & i_chan_low : 16'h0;
      default: return on & i_chan_high;
    endcase
  endfunction

  // Main sequence
  initial begin
    i_reset = 1'h1;
    i_blank = 1'h1;
    i_temp_warm = 1'h0;
    i_temp_hot = 1'h0;
    i_chan_low = 16'h3c3c;
    i_chan_high = 16'hc3a5;
    i_wb_cyc = 1'h0;
    i_wb_stb = 1'h0;
    i_wb_we = 1'h0;
    i_wb_adr = 8'h00;
    i_wb_dat = 32'h0;
    repeat (4) @(posedge i_clock);
    i_reset <= 1'h0;
    wb(1'h0, `ADR_CTRL, 32'h0, rd);
    check("ctrl", rd, {31'h0, `CTRL_RST});
    wb(1'h0, `ADR_STATUS, 32'h0, rd);
    check("status", rd, 32'h0);
    wb(1'h1, 8'h20, 32'hffff, rd);
    wb(1'h0, 8'h20, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    // Channel turn-on times once blank lifts
    i_display_ctrl_model.load_image(16'hffff);
    t_on = '{default: -1};
    i_blank <= 1'h0;
    for (int c = 0; c < 12; c++) begin
      @(posedge i_clock);
      for (int n = 0; n < 16; n++) if (o_sink_channels[n] === 1'h1 && t_on[n] < 0) t_on[n] = c;
    end
    for (int n = 0; n < 16; n++) check("stagger", 32'(t_on[n] - t_on[0]), 32'(n % 4));
    i_display_ctrl_model.load_image(img);
    wb(1'h0, `ADR_IMAGE, 32'h0, rd);
    check("image", rd, {16'h0, img});
    check("channels", o_sink_channels, img);
    i_display_ctrl_model.read_report(img, rep);
    check("plain shift", rep, img);
    // All six kinds, with and without blank
    for (int b = 0; b < 2; b++) begin
      i_blank <= b[0];
      for (int s = 0; s < 2; s++) begin
        for (int n = 1; n < 4; n++) begin
          i_display_ctrl_model.select(n, s[0]);
          if (s == 1) begin
            i_display_ctrl_model.pins(1'h0, 1'h0, 1'h0);
            check("test current", o_test_current, n != 2);
            if (n == 2) check("forced off", o_sink_channels, 32'h0);
            i_display_ctrl_model.pins(1'h1, 1'h0, 1'h0);
          end
          i_display_ctrl_model.read_report(img, rep);
          check("report", rep, expect_rep(n, s, b));
          check("restored", o_sink_channels, img & ~{16{b[0]}});
          wb(1'h0, `ADR_REPORT, 32'h0, rd);
          check("report reg", rd, {16'h0, expect_rep(n, s, b)});
        end
      end
    end
    // Detection off: the single count edge only shifts a zero in
    i_blank <= 1'h0;
    wb(1'h1, `ADR_CTRL, 32'h0, rd);
    i_display_ctrl_model.select(1, 1'h0);
    i_display_ctrl_model.read_report(img, rep);
    check("disabled", rep, 16'(img << 1));
    wb(1'h1, `ADR_CTRL, 32'h1, rd);
    // Five edges pick no kind; they only shift zeros in
    i_display_ctrl_model.select(5, 1'h0);
    i_display_ctrl_model.read_report(img, rep);
    check("count five", rep, 16'(img << 5));
    // Thermal flags and shutdown
    i_temp_warm <= 1'h1;
    i_display_ctrl_model.select(4, 1'h0);
    check("warm out", o_serial_out, 1'h1);
    wb(1'h0, `ADR_STATUS, 32'h0, rd);
    check("mode", rd[4:3], 2'h3);
    i_display_ctrl_model.pins(1'h0, 1'h0, 1'h1);
    i_temp_hot <= 1'h1;
    repeat (10) @(posedge i_clock);
    check("shut", {o_shutdown, o_sink_channels}, 17'h10000);
    i_temp_hot <= 1'h0;
    repeat (10) @(posedge i_clock);
    check("still shut", o_shutdown, 1'h1);
    i_temp_warm <= 1'h0;
    repeat (10) @(posedge i_clock);
    check("resumed", {o_shutdown, o_sink_channels}, {1'h0, img});
    tally_and_finish();
  end
endmodule
